/* dv/ilas_tx_model.sv */
// Lane 7 transmitter model: sends the 14 link configuration octets of an alignment sequence
`timescale 1ns/1ps
module ilas_tx_model (
    input  wire       clk,
    output reg        ilas_start,
    output reg        ilas_octet_valid,
    output reg  [7:0] ilas_octet
);
    initial begin
        ilas_start = 1'b0;
        ilas_octet_valid = 1'b0;
        ilas_octet = 8'h00;
    end
    // Octet k sits at cfg[8k+7:8k]; K travels as count minus one
    task send(input [111:0] cfg);
        integer k;
        begin
            @(posedge clk) ilas_start <= 1'b1;
            @(posedge clk) ilas_start <= 1'b0;
            for (k = 0; k < 14; k = k + 1) begin
                ilas_octet_valid <= 1'b1;
                ilas_octet <= cfg[8*k +: 8];
                @(posedge clk) ilas_octet_valid <= 1'b0;
                // Unqualified line shows junk, not a held copy
                ilas_octet <= ~cfg[8*k +: 8];
                @(posedge clk);
            end
        end
    endtask
endmodule // ilas_tx_model

/* dv/lane_config_sva.sv */
// Checker for the SPI pins and configuration outputs of the lane config register bank
`timescale 1ns/1ps
module lane_config_sva (
    input wire       clk,
    input wire       rstn,
    input wire       spi_sclk,
    input wire       spi_csb,
    input wire       spi_sdo,
    input wire       spi_sdo_oe,
    input wire [7:0] link_device_id_r,
    input wire [7:0] link_bank_id_r,
    input wire       multiframe_clock_adjust_direction_r,
    input wire       phase_adjust_request_r,
    input wire [4:0] lane0_number_r,
    input wire       descramble_en_r,
    input wire [4:0] frames_per_multiframe_m1_r,
    input wire [2:0] subclass_version_r,
    input wire       checksum_mode_r
);
    a_reset_values: assert property (@(posedge clk) !rstn |=> descramble_en_r
        && frames_per_multiframe_m1_r == 5'h1F && link_bank_id_r == 8'h00
        && subclass_version_r == 3'h0 && link_device_id_r == 8'h00 && !checksum_mode_r)
        else $error("configuration outputs not at reset values");
    a_sdo_reset_idle: assert property (@(posedge clk) !rstn |=> !spi_sdo_oe && !spi_sdo)
        else $error("read data driven during reset");
    // Select is synchronised, so the drive may linger a few cycles after deselect
    a_oe_after_csb: assert property (@(posedge clk) disable iff (!rstn)
        spi_csb [*6] |-> !spi_sdo_oe)
        else $error("read data driven while deselected");
    a_oe_start_fall: assert property (@(posedge clk) disable iff (!rstn)
        $rose(spi_sdo_oe) |-> !$past(spi_sclk, 2))
        else $error("read drive did not start after a serial clock fall");
    a_sdo_bit_fall: assert property (@(posedge clk) disable iff (!rstn)
        spi_sdo_oe && $past(spi_sdo_oe) && spi_sdo != $past(spi_sdo) |-> !$past(spi_sclk, 2))
        else $error("read bit changed away from a serial clock fall");
    a_id_write_frame: assert property (@(posedge clk) disable iff (!rstn)
        link_device_id_r != $past(link_device_id_r) || link_bank_id_r != $past(link_bank_id_r)
        |-> !$past(spi_csb, 3))
        else $error("identifier changed outside a write frame");
    a_lane0_write_frame: assert property (@(posedge clk) disable iff (!rstn)
        {multiframe_clock_adjust_direction_r, phase_adjust_request_r, lane0_number_r}
        != $past({multiframe_clock_adjust_direction_r, phase_adjust_request_r, lane0_number_r})
        |-> !$past(spi_csb, 3))
        else $error("lane 0 fields changed outside a write frame");
    a_misc_write_frame: assert property (@(posedge clk) disable iff (!rstn)
        {descramble_en_r, frames_per_multiframe_m1_r, subclass_version_r, checksum_mode_r}
        != $past({descramble_en_r, frames_per_multiframe_m1_r, subclass_version_r,
        checksum_mode_r}) |-> !$past(spi_csb, 3))
        else $error("link fields changed outside a write frame");
endmodule // lane_config_sva

/* dv/serial_link_rx_lane_config_regs_test.sv */
// Bench: reset values, access kinds, lane 7 capture and mid-run reset over SPI
`timescale 1ns/1ps
module serial_link_rx_lane_config_regs_test;
    // Row: write flag, 15-bit address, write data, expected readback
    localparam [32*25-1:0] ROWS = {
        32'h0442_0000, 32'h0445_0000, 32'h0446_0000, 32'h0450_0000, 32'h0451_0000,
        32'h0452_0000, 32'h0453_0087, 32'h0454_0000, 32'h0455_001F, 32'h0456_0001,
        32'h0457_000F, 32'h0458_000F, 32'h0300_0000, 32'h7FFF_0000, 32'h8450_ABAB,
        32'h8451_5A5A, 32'h8452_FF7F, 32'h8453_0007, 32'h8454_FF00, 32'h8455_EF0F,
        32'h8456_FF01, 32'h8457_FF0F, 32'h8458_3F2F, 32'h8442_FF00, 32'hFFFF_FF00};
    localparam [111:0] CFG = 112'hC400_0080_212F_2F01_1F01_87E3_935A;
    reg        clk = 1'b0;
    reg        rstn = 1'b0;
    reg        spi_sclk = 1'b0;
    reg        spi_csb = 1'b1;
    reg        spi_sdi = 1'b0;
    wire       spi_sdo, spi_sdo_oe, ilas_start, ilas_octet_valid;
    wire       adj_dir, ph_adj, scr_en, ck_mode;
    wire [7:0] ilas_octet, dev_id, bank_id;
    wire [4:0] lane0, k_m1;
    wire [2:0] subcl;
    integer    n_mismatch = 0;
    integer    n_checks = 0;
    integer    i;

    always #50 clk = ~clk;

    serial_link_rx_lane_config_regs dut (.clk(clk), .rstn(rstn), .spi_sclk(spi_sclk),
        .spi_csb(spi_csb), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
        .ilas_start(ilas_start), .ilas_octet_valid(ilas_octet_valid), .ilas_octet(ilas_octet),
        .link_device_id_r(dev_id), .link_bank_id_r(bank_id),
        .multiframe_clock_adjust_direction_r(adj_dir), .phase_adjust_request_r(ph_adj),
        .lane0_number_r(lane0), .descramble_en_r(scr_en), .frames_per_multiframe_m1_r(k_m1),
        .subclass_version_r(subcl), .checksum_mode_r(ck_mode));
    ilas_tx_model tx (.clk(clk), .ilas_start(ilas_start), .ilas_octet_valid(ilas_octet_valid),
        .ilas_octet(ilas_octet));

    task chk(input [8*8-1:0] what, input [15:0] id, input [7:0] exp, input [7:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value %0s %h expected %h seen %h", what, id, exp, got);
            end
        end
    endtask

    // Serial clock phases are four system clocks each to clear the pin synchronisers
    task spi_frame(input [23:0] word, output [7:0] dout);
        integer b;
        begin
            dout = 8'h00;
            @(posedge clk) spi_csb <= 1'b0;
            for (b = 23; b >= 0; b = b - 1) begin
                @(posedge clk) spi_sdi <= word[b];
                spi_sclk <= 1'b0;
                repeat (4) @(posedge clk);
                if (b < 8)
                    // Released line reads as the inverse, so a missing drive enable shows up
                    dout = {dout[6:0], spi_sdo_oe ? spi_sdo : ~spi_sdo};
                spi_sclk <= 1'b1;
                repeat (3) @(posedge clk);
            end
            repeat (4) @(posedge clk);
            spi_csb <= 1'b1;
            spi_sclk <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask

    task access(input [31:0] row);
        reg [7:0] rd;
        begin
            if (row[31])
                spi_frame({1'b0, row[30:8]}, rd);
            spi_frame({1'b1, row[30:16], 8'h00}, rd);
            chk("readback", {1'b0, row[30:16]}, row[7:0], rd);
        end
    endtask

    function [7:0] csum(input fld);
        integer k;
        reg [7:0] s, o;
        begin
            s = 8'h00;
            for (k = 0; k <= 10; k = k + 1) begin
                o = CFG[8*k +: 8];
                if (!fld)
                    s = s + o;
                else case (k)
                    1: s = s + o[7:4] + o[3:0];
                    2: s = s + o[6] + o[5] + o[4:0];
                    3, 10: s = s + o[7] + o[4:0];
                    5: s = s + o[4:0];
                    7: s = s + o[7:6] + o[4:0];
                    8, 9: s = s + o[7:5] + o[4:0];
                    default: s = s + o;
                endcase
            end
            csum = s;
        end
    endfunction

    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        end_sim;
    end

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        // Link fields are written before alignment traffic, as in soft reset; only checksum mode changes between the two sequences
        for (i = 0; i < 25; i = i + 1)
            access(ROWS[32*(24-i) +: 32]);
        $display("test register rows done");
        chk("dev_id", 16'h0450, 8'hAB, dev_id);
        chk("bank_id", 16'h0451, 8'h5A, bank_id);
        chk("lane0", 16'h0452, 8'h7F, {1'b0, adj_dir, ph_adj, lane0});
        chk("scr_k", 16'h0453, 8'h0F, {2'b00, scr_en, k_m1});
        chk("subcl", 16'h0458, 8'h01, {5'h00, subcl});
        $display("test output ports done");
        access(32'h8300_4040);
        chk("ck_mode", 16'h0300, 8'h01, {7'h00, ck_mode});
        tx.send(CFG);
        repeat (4) @(posedge clk);
        access(32'h0442_0003);
        access(32'h0445_00C4);
        access({16'h0446, 8'h00, csum(1'b0)});
        access(32'h8300_0000);
        chk("ck_mode", 16'h0300, 8'h00, {7'h00, ck_mode});
        tx.send(CFG);
        repeat (4) @(posedge clk);
        access({16'h0446, 8'h00, csum(1'b1)});
        $display("test lane 7 capture done");
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("scr_k", 16'h0453, 8'h3F, {2'b00, scr_en, k_m1});
        chk("dev_id", 16'h0450, 8'h00, dev_id);
        chk("ck_mode", 16'h0300, 8'h00, {7'h00, ck_mode});
        access(32'h0446_0000);
        access(32'h0452_0000);
        $display("test mid-run reset done");
        end_sim;
    end
endmodule // serial_link_rx_lane_config_regs_test

bind serial_link_rx_lane_config_regs lane_config_sva chk_i (.clk(clk), .rstn(rstn),
    .spi_sclk(spi_sclk), .spi_csb(spi_csb), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .link_device_id_r(link_device_id_r), .link_bank_id_r(link_bank_id_r),
    .multiframe_clock_adjust_direction_r(multiframe_clock_adjust_direction_r),
    .phase_adjust_request_r(phase_adjust_request_r), .lane0_number_r(lane0_number_r),
    .descramble_en_r(descramble_en_r), .frames_per_multiframe_m1_r(frames_per_multiframe_m1_r),
    .subclass_version_r(subclass_version_r), .checksum_mode_r(checksum_mode_r));

/* verilog/lane7_ilas_capture.v */
// Captures lane 7 initial alignment configuration: lane ID, received and computed checksum
`timescale 1ns/1ps
`include "lane_config_consts.vh"
module lane7_ilas_capture (
    input  wire       clk,
    input  wire       rstn,
    input  wire       checksum_mode,
    input  wire       ilas_start,
    input  wire       ilas_octet_valid,
    input  wire [7:0] ilas_octet,
    output reg  [4:0] lane7_received_id_field_r,
    output reg  [7:0] lane7_received_checksum_field_r,
    output reg  [7:0] lane7_computed_checksum_field_r
);
    reg [3:0] idx_r;
    reg [7:0] sum_r;
    reg       busy_r;

    // Field-wise contribution of one octet; mode 1 sums whole octets instead
    function [7:0] field_sum;
        input [3:0] idx;
        input [7:0] o;
        begin
            case (idx)
                4'd1:    field_sum = {4'h0, o[3:0]} + {4'h0, o[7:4]};
                4'd2:    field_sum = {3'h0, o[4:0]} + {7'h00, o[5]} + {7'h00, o[6]};
                4'd3:    field_sum = {3'h0, o[4:0]} + {7'h00, o[7]};
                4'd5:    field_sum = {3'h0, o[4:0]};
                4'd7:    field_sum = {6'h00, o[7:6]} + {3'h0, o[4:0]};
                4'd8:    field_sum = {5'h00, o[7:5]} + {3'h0, o[4:0]};
                4'd9:    field_sum = {5'h00, o[7:5]} + {3'h0, o[4:0]};
                4'd10:   field_sum = {7'h00, o[7]} + {3'h0, o[4:0]};
                default: field_sum = o;
            endcase
        end
    endfunction

    always @(posedge clk) begin
        if (!rstn) begin
            idx_r  <= 4'h0;
            sum_r  <= 8'h00;
            busy_r <= 1'b0;
            lane7_received_id_field_r       <= 5'h00;
            lane7_received_checksum_field_r <= 8'h00;
            lane7_computed_checksum_field_r <= 8'h00;
        end else if (ilas_start) begin
            idx_r  <= 4'h0;
            sum_r  <= 8'h00;
            busy_r <= 1'b1;
        end else if (busy_r && ilas_octet_valid) begin
            idx_r <= idx_r + 4'd1;
            if (idx_r <= `ILAS_LAST_SUM_OCTET)
                sum_r <= sum_r + (checksum_mode ? ilas_octet : field_sum(idx_r, ilas_octet));
            if (idx_r == `ILAS_LID_OCTET)
                lane7_received_id_field_r <= ilas_octet[4:0];
            if (idx_r == `ILAS_FCHK_OCTET) begin
                lane7_received_checksum_field_r <= ilas_octet;
                lane7_computed_checksum_field_r <= sum_r;
                busy_r <= 1'b0;
            end
        end
    end
endmodule // lane7_ilas_capture

/* verilog/lane_config_consts.vh */
// Register offsets, field positions, reset values and SPI framing constants
`ifndef LANE_CONFIG_CONSTS_VH
`define LANE_CONFIG_CONSTS_VH

`define ADDR_W                15
`define ADDR_CHECKSUM_MODE    15'h0300
`define ADDR_LANE7_LID        15'h0442
`define ADDR_LANE7_FCHK       15'h0445
`define ADDR_LANE7_FCMP       15'h0446
`define ADDR_DEVICE_ID        15'h0450
`define ADDR_BANK_ID          15'h0451
`define ADDR_LANE0_ID         15'h0452
`define ADDR_SCR_L            15'h0453
`define ADDR_OCTETS_F         15'h0454
`define ADDR_FRAMES_K         15'h0455
`define ADDR_CONVERTERS_M     15'h0456
`define ADDR_CS_N             15'h0457
`define ADDR_SUBCLASS_NP      15'h0458

`define CHECKSUM_MODE_BIT     6
`define MULTIFRAME_CLOCK_ADJUST_DIRECTION_BIT            6
`define PHASE_ADJUST_REQUEST_BIT             5
`define SCR_BIT               7

`define RST_DEVICE_ID         8'h00
`define RST_BANK_ID           8'h00
`define RST_LANE0_ID          7'h00
`define RST_SCR               1'b1
`define RST_LANES_M1          5'h07
`define RST_OCTETS_M1         8'h00
`define RST_FRAMES_M1         5'h1F
`define RST_CONVERTERS_M1     8'h01
`define RST_CS                2'h0
`define RST_RESOLUTION_M1     5'h0F
`define RST_SUBCLASS          3'h0
`define RST_SAMPLE_BITS_M1    5'h0F
`define RST_CHECKSUM_MODE     1'b0

// SPI frame: 1 direction bit, 15 address bits, 8 data bits
`define SPI_HDR_BITS          5'd16
`define SPI_FRAME_BITS        5'd24

// Lane configuration octets: checksum covers 0..10, checksum octet is 13
`define ILAS_LID_OCTET        4'd2
`define ILAS_SCR_OCTET        4'd3
`define ILAS_LAST_SUM_OCTET   4'd10
`define ILAS_FCHK_OCTET       4'd13

`endif

/* verilog/serial_link_rx_lane_config_regs.v */
// Receive link configuration register bank with lane 7 alignment readback
`timescale 1ns/1ps
`include "lane_config_consts.vh"

// Summary of operation
// - Lane 7 received lane ID is captured into read-only bits 4:0, upper bits zero.
// - Lane 7 received checksum octet is stored read-only.
// - Own checksum over lane 7 configuration is computed and shown beside the received one.
// - Writable 8-bit bank identifier, resets to zero.
// - Bit 6 of lane 0 register: writable multiframe clock adjust direction, subclass 2.
// - Bit 5 of lane 0 register: writable phase adjust request, subclass 2.
// - Writable 5-bit lane 0 number in bits 4:0, bit 7 reads zero.
// - Bit 7 enables descrambling, resets to one.
// - Lane count minus one is read-only, five bits, resets to 0x7.
// - Octets per frame minus one is read-only and does not configure receiver.
// - Writable frames per multiframe minus one in five bits; resets 0x1F, which is 32.
// - Converter count minus one is read-only, resets to 0x1.
// - Control bits per sample read zero.
// - Converter resolution reads 0x0F in a read-only five-bit field.
// - Writable 3-bit subclass in bits 7:5; 001 is subclass 1, resets zero.
// - Bit 6 at 0x300 selects checksum method used for computed checksums.
module serial_link_rx_lane_config_regs (
    input  wire       clk,
    input  wire       rstn,
    input  wire       spi_sclk,
    input  wire       spi_csb,
    input  wire       spi_sdi,
    output wire       spi_sdo,
    output wire       spi_sdo_oe,
    input  wire       ilas_start,
    input  wire       ilas_octet_valid,
    input  wire [7:0] ilas_octet,
    output reg  [7:0] link_device_id_r,
    output reg  [7:0] link_bank_id_r,
    output reg        multiframe_clock_adjust_direction_r,
    output reg        phase_adjust_request_r,
    output reg  [4:0] lane0_number_r,
    output reg        descramble_en_r,
    output reg  [4:0] frames_per_multiframe_m1_r,
    output reg  [2:0] subclass_version_r,
    output reg        checksum_mode_r
);
    wire                wr_stb;
    wire                rd_stb;
    wire [`ADDR_W-1:0]  addr;
    wire [7:0]          wdata;
    wire [4:0]          lid7;
    wire [7:0]          fchk7;
    wire [7:0]          fcmp7;
    reg  [7:0]          rdata_r;
    reg  [7:0]          rdata_nxt;

    // Read-only link parameters fixed by this receiver; not software-configurable
    wire [4:0] lanes_m1       = `RST_LANES_M1;
    wire [7:0] octets_m1      = `RST_OCTETS_M1;
    wire [7:0] converters_m1  = `RST_CONVERTERS_M1;
    wire [1:0] ctrl_bits      = `RST_CS;
    wire [4:0] resolution_m1  = `RST_RESOLUTION_M1;
    wire [4:0] sample_bits_m1 = `RST_SAMPLE_BITS_M1;

    spi_reg_port u_spi (
        .clk      (clk),
        .rstn     (rstn),
        .spi_sclk (spi_sclk),
        .spi_csb  (spi_csb),
        .spi_sdi  (spi_sdi),
        .sdo_r    (spi_sdo),
        .sdo_oe_r (spi_sdo_oe),
        .wr_stb_r (wr_stb),
        .rd_stb_r (rd_stb),
        .addr_r   (addr),
        .wdata_r  (wdata),
        .rdata    (rdata_r)
    );

    lane7_ilas_capture u_lane7 (
        .clk                             (clk),
        .rstn                            (rstn),
        .checksum_mode                   (checksum_mode_r),
        .ilas_start                      (ilas_start),
        .ilas_octet_valid                (ilas_octet_valid),
        .ilas_octet                      (ilas_octet),
        .lane7_received_id_field_r       (lid7),
        .lane7_received_checksum_field_r (fchk7),
        .lane7_computed_checksum_field_r (fcmp7)
    );

    // Writes are accepted at any time; keeping them to soft reset is software's duty
    always @(posedge clk) begin
        if (!rstn) begin
            link_device_id_r                    <= `RST_DEVICE_ID;
            link_bank_id_r                      <= `RST_BANK_ID;
            multiframe_clock_adjust_direction_r <= 1'b0;
            phase_adjust_request_r              <= 1'b0;
            lane0_number_r                      <= 5'h00;
            descramble_en_r                     <= `RST_SCR;
            frames_per_multiframe_m1_r          <= `RST_FRAMES_M1;
            subclass_version_r                  <= `RST_SUBCLASS;
            checksum_mode_r                     <= `RST_CHECKSUM_MODE;
        end else if (wr_stb) begin
            case (addr)
                `ADDR_DEVICE_ID:
                    link_device_id_r <= wdata;
                `ADDR_BANK_ID:
                    link_bank_id_r <= wdata;
                `ADDR_LANE0_ID: begin
                    multiframe_clock_adjust_direction_r <= wdata[`MULTIFRAME_CLOCK_ADJUST_DIRECTION_BIT];
                    phase_adjust_request_r <= wdata[`PHASE_ADJUST_REQUEST_BIT];
                    lane0_number_r <= wdata[4:0];
                end
                `ADDR_SCR_L:
                    descramble_en_r <= wdata[`SCR_BIT];
                `ADDR_FRAMES_K:
                    frames_per_multiframe_m1_r <= wdata[4:0];
                `ADDR_SUBCLASS_NP:
                    subclass_version_r <= wdata[7:5];
                `ADDR_CHECKSUM_MODE:
                    checksum_mode_r <= wdata[`CHECKSUM_MODE_BIT];
                default: ;
            endcase
        end
    end

    // Unmapped addresses read zero; reserved bits read zero
    always @* begin
        rdata_nxt = 8'h00;
        case (addr)
            `ADDR_LANE7_LID:     rdata_nxt = {3'h0, lid7};
            `ADDR_LANE7_FCHK:    rdata_nxt = fchk7;
            `ADDR_LANE7_FCMP:    rdata_nxt = fcmp7;
            `ADDR_DEVICE_ID:     rdata_nxt = link_device_id_r;
            `ADDR_BANK_ID:       rdata_nxt = link_bank_id_r;
            `ADDR_LANE0_ID:      rdata_nxt = {1'b0, multiframe_clock_adjust_direction_r,
                                              phase_adjust_request_r, lane0_number_r};
            `ADDR_SCR_L:         rdata_nxt = {descramble_en_r, 2'h0, lanes_m1};
            `ADDR_OCTETS_F:      rdata_nxt = octets_m1;
            `ADDR_FRAMES_K:      rdata_nxt = {3'h0, frames_per_multiframe_m1_r};
            `ADDR_CONVERTERS_M:  rdata_nxt = converters_m1;
            `ADDR_CS_N:          rdata_nxt = {ctrl_bits, 1'b0, resolution_m1};
            `ADDR_SUBCLASS_NP:   rdata_nxt = {subclass_version_r, sample_bits_m1};
            `ADDR_CHECKSUM_MODE: rdata_nxt = {1'b0, checksum_mode_r, 6'h00};
            default:             rdata_nxt = 8'h00;
        endcase
    end

    // Read data is frozen at the end of the instruction so later edges cannot tear it
    always @(posedge clk) begin
        if (!rstn)
            rdata_r <= 8'h00;
        else if (rd_stb)
            rdata_r <= rdata_nxt;
    end
endmodule // serial_link_rx_lane_config_regs

/* verilog/spi_reg_port.v */
// SPI slave: synchronises the pins, frames instruction and data, shifts read data out
`timescale 1ns/1ps
`include "lane_config_consts.vh"
module spi_reg_port (
    input  wire                 clk,
    input  wire                 rstn,
    input  wire                 spi_sclk,
    input  wire                 spi_csb,
    input  wire                 spi_sdi,
    output reg                  sdo_r,
    output reg                  sdo_oe_r,
    output reg                  wr_stb_r,
    output reg                  rd_stb_r,
    output reg  [`ADDR_W-1:0]   addr_r,
    output reg  [7:0]           wdata_r,
    input  wire [7:0]           rdata
);
    reg  [2:0]  sclk_s;
    reg  [1:0]  csb_s;
    reg  [1:0]  sdi_s;
    reg  [4:0]  bit_cnt_r;
    reg         read_r;
    reg  [23:0] shift_r;
    reg  [7:0]  tx_r;
    reg         tx_load_r;
    wire        rise = sclk_s[1] & ~sclk_s[2];
    wire        fall = ~sclk_s[1] & sclk_s[2];
    wire        active = ~csb_s[1];

    // SCLK must run well below clk/4 since every pin is sampled through two flops
    always @(posedge clk) begin
        if (!rstn) begin
            sclk_s    <= 3'h0;
            csb_s     <= 2'h3;
            sdi_s     <= 2'h0;
            bit_cnt_r <= 5'h00;
            read_r    <= 1'b0;
            shift_r   <= 24'h000000;
            tx_r      <= 8'h00;
            tx_load_r <= 1'b0;
            sdo_r     <= 1'b0;
            sdo_oe_r  <= 1'b0;
            wr_stb_r  <= 1'b0;
            rd_stb_r  <= 1'b0;
            addr_r    <= {`ADDR_W{1'b0}};
            wdata_r   <= 8'h00;
        end else begin
            sclk_s   <= {sclk_s[1:0], spi_sclk};
            csb_s    <= {csb_s[0], spi_csb};
            sdi_s    <= {sdi_s[0], spi_sdi};
            wr_stb_r <= 1'b0;
            rd_stb_r <= 1'b0;
            if (!active) begin
                bit_cnt_r <= 5'h00;
                tx_load_r <= 1'b0;
                sdo_oe_r  <= 1'b0;
            end else if (rise && bit_cnt_r < `SPI_FRAME_BITS) begin
                shift_r   <= {shift_r[22:0], sdi_s[1]};
                bit_cnt_r <= bit_cnt_r + 5'd1;
                if (bit_cnt_r == `SPI_HDR_BITS - 5'd1) begin
                    read_r   <= shift_r[14];
                    addr_r   <= {shift_r[13:0], sdi_s[1]};
                    rd_stb_r <= shift_r[14];
                    tx_load_r <= shift_r[14];
                end
                if (bit_cnt_r == `SPI_FRAME_BITS - 5'd1 && !read_r) begin
                    wdata_r  <= {shift_r[6:0], sdi_s[1]};
                    wr_stb_r <= 1'b1;
                end
            end else if (fall && read_r && bit_cnt_r >= `SPI_HDR_BITS) begin
                // Data phase: first falling edge loads the byte, later ones shift it
                sdo_oe_r <= (bit_cnt_r < `SPI_FRAME_BITS);
                if (tx_load_r) begin
                    tx_load_r <= 1'b0;
                    sdo_r     <= rdata[7];
                    tx_r      <= {rdata[6:0], 1'b0};
                end else begin
                    sdo_r <= tx_r[7];
                    tx_r  <= {tx_r[6:0], 1'b0};
                end
            end
        end
    end
endmodule // spi_reg_port
